// [rtl/svc_pkg.sv]
`default_nettype none
package svc_pkg;
   // ==============================================================
   // configuration register layout
   localparam int CFG_W = 8;
   localparam int CFG_PKG_TYPE_BIT = 7;
   localparam int CFG_REG_ACK_EN_BIT = 6;
   localparam int CFG_CHAIN_EN_BIT = 5;
   localparam int CFG_GLOBAL_BIT = 4;
   localparam int CFG_FAIR_OVR_BIT = 3;
   localparam int CFG_RESERVED_BIT = 2;
   localparam int CFG_AUTO_BIT = 1;
   localparam int CFG_ORDER_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic PKG_TYPE_VALUE = 1'b0; // arbitrary value
   // ==============================================================
   // acknowledge types and request classes
   localparam logic [1:0] TYPE_MODEM = 2'h1;
   localparam logic [1:0] TYPE_TX = 2'h2;
   localparam logic [1:0] TYPE_RX = 2'h3;
   localparam int CLS_RX = 0;
   localparam int CLS_TX = 1;
   localparam int CLS_MODEM = 2;
   // vector modification codes, low three bits of the answer
   localparam logic [2:0] MOD_NONE = 3'h0;
   localparam logic [2:0] MOD_MODEM = 3'h1;
   localparam logic [2:0] MOD_TX = 3'h2;
   localparam logic [2:0] MOD_RX = 3'h3;
   localparam logic [4:0] VECTOR_BASE = 5'h1F;
   // ==============================================================
   // host controller register map (byte addresses)
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_ACK_CMD = 8'h04;
   localparam logic [7:0] OFS_ACK_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
   localparam int CMD_REG_BIT = 2;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_REQ_BIT = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic {DEV_IDLE = 1'b0, DEV_HOLD = 1'b1} dev_state_t;
   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_WAIT = 2'b01,
      HOST_REL = 2'b10
   } host_state_t;
endpackage : svc_pkg
`default_nettype wire

// [rtl/svc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// link between the serial controller and the host processor
interface svc_link_if;
   logic [2:0] req; // {modem, tx, rx}, active high
   logic [2:0] shared_request_line; // wire-OR of all cascaded devices
   logic ack_chain_in_n;
   logic reg_ack_rd;
   logic [1:0] ack_type;
   logic ack_chain_out_n;
   logic resp_valid;
   logic [7:0] resp_vector;
   logic cfg_wr;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   modport device (
      output req, input shared_request_line, input ack_chain_in_n, input reg_ack_rd,
      input ack_type, output ack_chain_out_n, output resp_valid, output resp_vector,
      input cfg_wr, input cfg_wdata, output cfg_rdata
   );
   modport host (
      input req, input shared_request_line, output ack_chain_in_n, output reg_ack_rd,
      output ack_type, input ack_chain_out_n, input resp_valid, input resp_vector,
      output cfg_wr, output cfg_wdata, input cfg_rdata
   );
endinterface : svc_link_if
`default_nettype wire

// [rtl/svc_request_device.sv]
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module svc_request_device (
   input wire logic hclk,
   input wire logic hresetn,
   svc_link_if.device link,
   input wire logic rx_pending,
   input wire logic tx_pending,
   input wire logic modem_pending,
   input wire logic [2:0] fair_flag,
   output logic serviced_valid,
   output logic [1:0] serviced_class
);
   // ==============================================================
   // configuration register
   logic [7:0] cfg_q;
   logic reg_ack_en;
   logic chain_en;
   logic global_sel;
   logic fair_ovr;
   logic auto_en;
   logic order_sel;

   assign reg_ack_en = cfg_q[svc_pkg::CFG_REG_ACK_EN_BIT];
   assign chain_en = cfg_q[svc_pkg::CFG_CHAIN_EN_BIT];
   assign global_sel = cfg_q[svc_pkg::CFG_GLOBAL_BIT];
   assign fair_ovr = cfg_q[svc_pkg::CFG_FAIR_OVR_BIT];
   assign auto_en = cfg_q[svc_pkg::CFG_AUTO_BIT];
   assign order_sel = cfg_q[svc_pkg::CFG_ORDER_BIT];

   // write from host; fixed bit and reserved bit are not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= svc_pkg::CFG_RESET;
      end else if (link.cfg_wr) begin
         cfg_q <= {svc_pkg::PKG_TYPE_VALUE, link.cfg_wdata[6:3], 1'b0, link.cfg_wdata[1:0]};
      end
   end

   assign link.cfg_rdata = cfg_q;

   // ==============================================================
   // request generation with fair share gating
   logic [2:0] fair_eff;
   logic [2:0] local_req;
   logic [2:0] req_q;

   assign fair_eff = fair_ovr ? 3'h7 : fair_flag;
   assign local_req = {modem_pending, tx_pending, rx_pending} & fair_eff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= 3'h0;
      end else begin
         req_q <= local_req;
      end
   end

   assign link.req = req_q;

   // ==============================================================
   // arbitration
   // returns {found, class}; modem is always last
   function automatic logic [2:0] pick_top(input logic [2:0] pool, input logic tx_first);
      logic [2:0] res;
      res = 3'h0;
      // order bit picks rx or tx first
      if (tx_first && pool[svc_pkg::CLS_TX]) begin
         res = {1'b1, 2'(svc_pkg::CLS_TX)};
      end else if (pool[svc_pkg::CLS_RX]) begin
         res = {1'b1, 2'(svc_pkg::CLS_RX)};
      end else if (pool[svc_pkg::CLS_TX]) begin
         res = {1'b1, 2'(svc_pkg::CLS_TX)};
      end else if (pool[svc_pkg::CLS_MODEM]) begin
         res = {1'b1, 2'(svc_pkg::CLS_MODEM)};
      end
      return res;
   endfunction : pick_top

   logic hw_cyc;
   logic reg_cyc;
   logic reg_ok;
   logic auto_sel;
   logic [2:0] pool;
   logic [2:0] top;
   logic [1:0] cls;
   logic claim;
   logic pass;

   assign hw_cyc = !link.ack_chain_in_n;
   assign reg_cyc = link.reg_ack_rd;
   // register ack honoured only when enabled
   assign reg_ok = reg_cyc && reg_ack_en;
   // auto priority only on type 1
   assign auto_sel = auto_en && (link.ack_type == svc_pkg::TYPE_MODEM);
   assign pool = global_sel ? link.shared_request_line : local_req;
   assign top = pick_top(pool, order_sel);

   // choose class, then claim only if this device has it pending
   always_comb begin
      cls = 2'(svc_pkg::CLS_MODEM);
      claim = 1'b0;
      if (auto_sel) begin
         cls = top[1:0];
         claim = top[2] && local_req[cls];
      end else begin
         // types 2 and 3 stay exact
         unique case (link.ack_type)
            svc_pkg::TYPE_TX: cls = 2'(svc_pkg::CLS_TX);
            svc_pkg::TYPE_RX: cls = 2'(svc_pkg::CLS_RX);
            default: cls = 2'(svc_pkg::CLS_MODEM);
         endcase
         claim = (link.ack_type != 2'h0) && local_req[cls];
      end
      if (reg_cyc && !reg_ok) begin
         claim = 1'b0;
      end
   end

   assign pass = !claim && (hw_cyc || (reg_ok && chain_en));

   // ==============================================================
   // acknowledge cycle: answer once, hold until host releases
   svc_pkg::dev_state_t state_q;
   logic resp_valid_q;
   logic [7:0] resp_vector_q;
   logic chain_out_n_q;
   logic serviced_valid_q;
   logic [1:0] serviced_class_q;
   logic [2:0] mod_code;

   always_comb begin
      unique case (cls)
         2'(svc_pkg::CLS_RX): mod_code = svc_pkg::MOD_RX;
         2'(svc_pkg::CLS_TX): mod_code = svc_pkg::MOD_TX;
         default: mod_code = svc_pkg::MOD_MODEM;
      endcase
   end

   // cycle state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= svc_pkg::DEV_IDLE;
      end else begin
         unique case (state_q)
            svc_pkg::DEV_IDLE: begin
               if (hw_cyc || reg_cyc) begin
                  state_q <= svc_pkg::DEV_HOLD;
               end
            end
            svc_pkg::DEV_HOLD: begin
               if (!hw_cyc && !reg_cyc) begin
                  state_q <= svc_pkg::DEV_IDLE;
               end
            end
         endcase
      end
   end

   // answer lines
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_valid_q <= 1'b0;
         resp_vector_q <= 8'h00;
         chain_out_n_q <= 1'b1;
      end else if (state_q == svc_pkg::DEV_IDLE) begin
         if (hw_cyc || reg_cyc) begin
            resp_valid_q <= !pass;
            chain_out_n_q <= !pass;
            resp_vector_q <= {svc_pkg::VECTOR_BASE, claim ? mod_code : svc_pkg::MOD_NONE};
         end
      end else if (!hw_cyc && !reg_cyc) begin
         resp_valid_q <= 1'b0;
         chain_out_n_q <= 1'b1;
      end
   end

   // one pulse to the claimed channel class
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serviced_valid_q <= 1'b0;
         serviced_class_q <= 2'h0;
      end else begin
         serviced_valid_q <= (state_q == svc_pkg::DEV_IDLE) && (hw_cyc || reg_cyc) && claim;
         if ((state_q == svc_pkg::DEV_IDLE) && (hw_cyc || reg_cyc) && claim) begin
            serviced_class_q <= cls;
         end
      end
   end

   assign link.resp_valid = resp_valid_q;
   assign link.resp_vector = resp_vector_q;
   assign link.ack_chain_out_n = chain_out_n_q;
   assign serviced_valid = serviced_valid_q;
   assign serviced_class = serviced_class_q;
endmodule : svc_request_device
`default_nettype wire

// [rtl/svc_request_host.sv]
`timescale 1ns/1ps
`default_nettype none
module svc_request_host (
   input wire logic hclk,
   input wire logic hresetn,
   svc_link_if.host link,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq
);
   // ==============================================================
   // bus slave: zero wait states, read data captured in address phase
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic addr_ok;
   logic [7:0] cfg_shadow_q;
   logic [1:0] ack_type_q;
   logic [7:0] vector_q;
   logic passed_q;
   logic claimed_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_en_q;
   svc_pkg::host_state_t state_q;

   assign addr_ok = hsel && hready && (htrans == svc_pkg::HTRANS_NONSEQ);

   always_comb begin
      unique case (haddr[7:0])
         svc_pkg::OFS_CFG: rd_mux = {24'h0, link.cfg_rdata};
         svc_pkg::OFS_ACK_STAT: rd_mux = {13'h0, link.req, vector_q, 5'h0, claimed_q, passed_q,
            state_q != svc_pkg::HOST_IDLE};
         svc_pkg::OFS_IRQ_STATUS: rd_mux = {30'h0, irq_stat_q};
         svc_pkg::OFS_IRQ_ENABLE: rd_mux = {30'h0, irq_en_q};
         default: rd_mux = 32'h0;
      endcase
   end

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_q <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   logic wr_cfg;
   logic wr_cmd;
   assign wr_cfg = wr_pend_q && (wr_addr_q == svc_pkg::OFS_CFG);
   assign wr_cmd = wr_pend_q && (wr_addr_q == svc_pkg::OFS_ACK_CMD);

   // ==============================================================
   // configuration forwarded to the device
   logic cfg_wr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_wr_q <= 1'b0;
         cfg_shadow_q <= svc_pkg::CFG_RESET;
      end else begin
         cfg_wr_q <= wr_cfg;
         if (wr_cfg) begin
            cfg_shadow_q <= {hwdata[7:3], 1'b0, hwdata[1:0]};
         end
      end
   end
   assign link.cfg_wr = cfg_wr_q;
   assign link.cfg_wdata = cfg_shadow_q;

   // ==============================================================
   // acknowledge cycle sequencer
   logic chain_in_n_q;
   logic reg_rd_q;
   logic got;
   assign got = link.resp_valid || !link.ack_chain_out_n;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= svc_pkg::HOST_IDLE;
         chain_in_n_q <= 1'b1;
         reg_rd_q <= 1'b0;
         ack_type_q <= 2'h0;
         vector_q <= 8'h00;
         passed_q <= 1'b0;
         claimed_q <= 1'b0;
      end else begin
         unique case (state_q)
            svc_pkg::HOST_IDLE: begin
               if (wr_cmd) begin
                  ack_type_q <= hwdata[1:0];
                  reg_rd_q <= hwdata[svc_pkg::CMD_REG_BIT];
                  chain_in_n_q <= hwdata[svc_pkg::CMD_REG_BIT];
                  state_q <= svc_pkg::HOST_WAIT;
               end
            end
            svc_pkg::HOST_WAIT: begin
               if (got) begin
                  vector_q <= link.resp_vector;
                  passed_q <= !link.ack_chain_out_n;
                  claimed_q <= link.resp_valid;
                  chain_in_n_q <= 1'b1;
                  reg_rd_q <= 1'b0;
                  state_q <= svc_pkg::HOST_REL;
               end
            end
            svc_pkg::HOST_REL: begin
               if (!got) begin
                  state_q <= svc_pkg::HOST_IDLE;
               end
            end
            default: state_q <= svc_pkg::HOST_IDLE;
         endcase
      end
   end
   assign link.ack_chain_in_n = chain_in_n_q;
   assign link.reg_ack_rd = reg_rd_q;
   assign link.ack_type = ack_type_q;

   // ==============================================================
   // interrupts: sticky status, write-one clear, enable; set wins
   logic [2:0] req_seen_q;
   logic [1:0] ev;
   assign ev = {|(link.req & ~req_seen_q),
      (state_q == svc_pkg::HOST_WAIT) && got};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_seen_q <= 3'h0;
         irq_stat_q <= 2'h0;
         irq_en_q <= 2'h0;
         irq <= 1'b0;
      end else begin
         req_seen_q <= link.req;
         if (wr_pend_q && (wr_addr_q == svc_pkg::OFS_IRQ_CLEAR)) begin
            irq_stat_q <= (irq_stat_q & ~hwdata[1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         if (wr_pend_q && (wr_addr_q == svc_pkg::OFS_IRQ_ENABLE)) begin
            irq_en_q <= hwdata[1:0];
         end
         irq <= |(irq_stat_q & irq_en_q);
      end
   end
endmodule : svc_request_host
`default_nettype wire

// [testbench/svc_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// link protocol checker
module svc_link_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] req,
   input wire logic [2:0] shared_request_line,
   input wire logic ack_chain_in_n,
   input wire logic reg_ack_rd,
   input wire logic [1:0] ack_type,
   input wire logic ack_chain_out_n,
   input wire logic resp_valid,
   input wire logic [7:0] resp_vector,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic idle, hw_ack, rg_ack, amod, gclaim;
   logic [2:0] top_l, top_g;
   // modification code of the top class in a request set
   function automatic logic [2:0] top_code(input logic [2:0] r, input logic o);
      if (r[0] && !(o && r[1])) return 3'h3;
      if (r[1]) return 3'h2;
      if (r[2]) return 3'h1;
      return 3'h0;
   endfunction : top_code
   // ack starts and auto-priority decode
   assign idle = !resp_valid && ack_chain_out_n;
   assign hw_ack = !ack_chain_in_n && idle;
   assign rg_ack = reg_ack_rd && idle;
   assign amod = cfg_rdata[1] && ack_type == 2'h1;
   assign top_l = top_code(req, cfg_rdata[0]);
   assign top_g = top_code(shared_request_line, cfg_rdata[0]);
   assign gclaim = top_g == 3'h3 ? req[0] : (top_g == 3'h2 ? req[1] : req[2]);
   // ==============================================================
   // assertions
   reg_off_a: assert property ($rose(reg_ack_rd) && rg_ack && !cfg_rdata[6]
      |=> resp_valid && resp_vector[2:0] == svc_pkg::MOD_NONE) else $error("reg ack off not taken");
   chain_pass_a: assert property ($rose(reg_ack_rd) && rg_ack && cfg_rdata[6:5] == 2'h3
      && req == 3'h0 |=> !ack_chain_out_n && !resp_valid) else $error("reg ack not passed");
   reg_take_a: assert property ($rose(reg_ack_rd) && rg_ack && !cfg_rdata[5] && req == 3'h0
      |=> resp_valid && resp_vector[2:0] == svc_pkg::MOD_NONE) else $error("reg ack not taken");
   hw_pass_a: assert property ($fell(ack_chain_in_n) && hw_ack && req == 3'h0
      |=> !ack_chain_out_n && !resp_valid) else $error("hw ack not passed");
   exact_class_a: assert property ($fell(ack_chain_in_n) && hw_ack
      && ((ack_type == svc_pkg::TYPE_RX && req[0]) || (ack_type == svc_pkg::TYPE_TX && req[1]))
      |=> resp_valid && resp_vector[2:0] == {1'h0, ack_type}) else $error("class changed");
   local_order_a: assert property ($fell(ack_chain_in_n) && hw_ack && amod && !cfg_rdata[4]
      && req != 3'h0 |=> resp_valid && resp_vector[2:0] == $past(top_l)) else $error("local order");
   global_order_a: assert property ($fell(ack_chain_in_n) && hw_ack && amod && cfg_rdata[4]
      && top_g != 3'h0 |=> resp_valid == $past(gclaim)
      && (!resp_valid || resp_vector[2:0] == $past(top_g))) else $error("global order");
   cfg_write_a: assert property (cfg_wr |=> cfg_rdata[6:3] == $past(cfg_wdata[6:3])
      && cfg_rdata[1:0] == $past(cfg_wdata[1:0]) && cfg_rdata[2] == 1'h0) else $error("cfg value");
   // main scenarios
   cover property ($rose(reg_ack_rd) && cfg_rdata[6:5] == 2'h3);
   cover property ($fell(ack_chain_in_n) && amod && cfg_rdata[4]);
   cover property (resp_valid && resp_vector[2:0] == svc_pkg::MOD_MODEM);
endmodule : svc_link_sva
`default_nettype wire

// [testbench/service_request_priority_ack_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module service_request_priority_ack_tb;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, sv_valid;
   logic [2:0] pend, fair, hsize;
   logic [1:0] htrans, sv_class;
   logic [31:0] haddr, hwdata, hrdata;
   int error_cnt, check_count;
   int sv_cnt = 0;
   svc_link_if link ();
   assign hready = hreadyout;
   // count service pulses, sampled one edge after launch
   always @(posedge hclk) begin
      if (sv_valid === 1'h1) begin
         sv_cnt <= sv_cnt + 1;
      end
   end
   // ==============================================================
   // both ends and the checker
   svc_request_device i_svc_request_device (.hclk(hclk), .hresetn(hresetn), .link(link.device),
      .rx_pending(pend[0]), .tx_pending(pend[1]), .modem_pending(pend[2]), .fair_flag(fair),
      .serviced_valid(sv_valid), .serviced_class(sv_class));
   svc_request_host i_svc_request_host (.hclk(hclk), .hresetn(hresetn), .link(link.host),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .irq(irq));
   svc_link_sva i_svc_link_sva (.hclk(hclk), .hresetn(hresetn), .req(link.req),
      .shared_request_line(link.shared_request_line), .ack_chain_in_n(link.ack_chain_in_n),
      .reg_ack_rd(link.reg_ack_rd), .ack_type(link.ack_type),
      .ack_chain_out_n(link.ack_chain_out_n), .resp_valid(link.resp_valid),
      .resp_vector(link.resp_vector), .cfg_wr(link.cfg_wr), .cfg_wdata(link.cfg_wdata),
      .cfg_rdata(link.cfg_rdata));
   // ==============================================================
   // checking and closing
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // single word transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= svc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
      chk("hresp", hresp, 32'h0);
   endtask : bus
   // outcome of one ack: {passed, modification code}
   function automatic logic [3:0] model(input logic [7:0] c, input logic [1:0] t,
      input logic r, input logic [2:0] p, input logic [2:0] s);
      logic [2:0] pool;
      int cls;
      if (r && !c[6]) return 4'h0;
      pool = c[4] ? s : p;
      cls = 3;
      if (c[1] && t == 2'h1) begin
         if (pool[0] && !(c[0] && pool[1])) cls = 0;
         else if (pool[1]) cls = 1;
         else if (pool[2]) cls = 2;
      end else if (t != 2'h0) cls = 3 - t;
      if (cls < 3 && p[cls]) return {1'h0, 3'(3 - cls)};
      return {!r || c[5], 3'h0};
   endfunction : model
   // ==============================================================
   // clock, watchdog and main sequence
   initial begin
      hclk = 1'h0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      logic [7:0] c;
      logic [1:0] t;
      logic [2:0] pn, ot;
      logic [31:0] rd;
      logic [3:0] e;
      logic r, en;
      int k;
      int sv_exp;
      hresetn = 1'h0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata, pend} = '0;
      fair = 3'h7;
      link.shared_request_line = 3'h0;
      error_cnt = 0;
      check_count = 0;
      sv_exp = 0;
      void'($urandom(32'hF125157C));
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      bus(1'h0, svc_pkg::OFS_CFG, 32'h0, rd);
      chk("cfg reset", rd, 32'h0);
      bus(1'h0, 8'h18, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      for (int i = 0; i < 60; i++) begin
         c = 8'($urandom());
         c[2] = 1'h0;
         {t, r, pn, ot} = 9'($urandom());
         en = i > 0;
         pend <= pn;
         fair <= 3'($urandom());
         if (i % 4 == 3) begin
            c[4] = 1'h0;
         end
         link.shared_request_line <= (i % 4 == 3) ? {3{|(pn | ot)}} : pn | ot;
         bus(1'h1, svc_pkg::OFS_CFG, {24'h0, c}, rd);
         bus(1'h1, svc_pkg::OFS_IRQ_ENABLE, {31'h0, en}, rd);
         bus(1'h0, svc_pkg::OFS_CFG, 32'h0, rd);
         chk("cfg", rd, {24'h0, svc_pkg::PKG_TYPE_VALUE, c[6:3], 1'h0, c[1:0]});
         chk("req", link.req, pn & (fair | {3{c[3]}}));
         fair <= 3'h7;
         bus(1'h1, svc_pkg::OFS_ACK_CMD, {29'h0, r, t}, rd);
         k = 0;
         do begin
            bus(1'h0, svc_pkg::OFS_IRQ_STATUS, 32'h0, rd);
            k++;
         end while (rd[0] !== 1'h1 && k < 20);
         chk("ack done", rd[0], 32'h1);
         chk("irq", irq, en);
         bus(1'h0, svc_pkg::OFS_ACK_STAT, 32'h0, rd);
         e = model(c, t, r, pn, pn | ot);
         chk("passed", rd[1], e[3]);
         chk("claimed", rd[2], !e[3]);
         chk("stat req", rd[18:16], pn);
         if (!e[3]) chk("vector", rd[15:8], {svc_pkg::VECTOR_BASE, e[2:0]});
         if (e[2:0] != 3'h0) chk("class", sv_class, 2'(3 - e[2:0]));
         if (e[2:0] != 3'h0) sv_exp++;
         chk("serviced", sv_cnt, sv_exp);
         bus(1'h1, svc_pkg::OFS_IRQ_CLEAR, 32'h3, rd);
         bus(1'h0, svc_pkg::OFS_IRQ_STATUS, 32'h0, rd);
         chk("status clear", rd[1:0], 32'h0);
         chk("irq low", irq, 32'h0);
      end
      complete_run();
   end
endmodule : service_request_priority_ack_tb
`default_nettype wire
